/* File: inc/rup_consts.vh */
// Constants of the RS-485 user port: framing, timing, characters, modes.
// Assumes inclusion by bare name from the user port design files.
`ifndef RUP_CONSTS_VH
`define RUP_CONSTS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define RUP_CLK_HZ 100000000
`define RUP_BAUD 4800
`define RUP_BAUD_MAX 19200
`define RUP_CNT_W 15
`define RUP_SYNC_SETTLE 2'h3

// ----------------------------------------
// Framing: start, 7 data, even parity, 1 stop
// ----------------------------------------
`define RUP_DATA_BITS 7
`define RUP_FRAME_BITS 4'ha
`define RUP_BIT_IDX_W 4
`define RUP_PAR_POS 4'h8
`define RUP_STOP_POS 4'h9

// ----------------------------------------
// Characters
// ----------------------------------------
`define RUP_CHAR_CR 7'h0d
`define RUP_CHAR_ESC 7'h1b

// ----------------------------------------
// Serial output modes as held in storage
// ----------------------------------------
`define RUP_MODE_STOP 2'h0
`define RUP_MODE_RUN 2'h1
`define RUP_MODE_POLL 2'h2
`define RUP_MODE_SEND 2'h3

// ----------------------------------------
// Transmit buffer
// ----------------------------------------
`define RUP_FIFO_DEPTH 16
`define RUP_FIFO_AW 4

`endif

/* File: core/rup_fifo.v */
// Small synchronous FIFO with a registered output stage.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module rup_fifo #(
  parameter WIDTH = 7,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  reg [WIDTH-1:0] dout_q;
  reg dval_q;
  wire push;
  wire load;

  // ----------------------------------------
  // Storage and output stage
  // ----------------------------------------
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  // Output register refills when memory holds an entry and the register is empty or being drained
  assign load = (cnt_q != {(AW+1){1'b0}}) && (!dval_q || out_ready);
  assign out_data = dout_q;
  assign out_valid = dval_q;

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      dout_q <= {WIDTH{1'b0}};
      dval_q <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (load) begin
        rp_q <= rp_q + 1'b1;
        dout_q <= mem[rp_q];
        dval_q <= 1'b1;
      end else if (out_ready) begin
        dval_q <= 1'b0;
      end
      if (push && !load) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (load && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

/* File: core/rup_user_port.v */
// RS-485 user port: 7E1 UART, start-up by stored mode, run/stop control.
// Assumes firmware feeds characters and decodes lines; persistent store is outside.
//
// Notes on behaviour
// - The link is two-wire half duplex and never runs above 19200 bit/s; BIT_CYCLES is not checked against RUP_BAUD_MAX.
// - After reset the port runs 4800 baud, even parity, 7 data bits, 1 stop bit, no flow control.
// - Received characters are never sent back; echo is left to the host.
// - While the port is sending, incoming characters are dropped; the host waits for the full answer.
// - An escape character from the host ends continuous output.
// - Starting in stop mode, the port sends a version line and prompt before taking commands.
// - Starting in run mode, measurement output starts at once.
// - Starting in poll mode, the port stays silent until addressed.
// - The mode chosen by the mode-select command is stored and used at every later power-up.
// - Run-output enters temporary continuous output and stop ends it, after which all commands are taken.
`timescale 1ns/1ps
`include "rup_consts.vh"
module rup_user_port #(
  parameter BIT_CYCLES = `RUP_CLK_HZ / `RUP_BAUD
) (
  input wire sys_clk,
  input wire rst,
  input wire adjust_button,
  input wire passive_variant,
  input wire [1:0] stored_mode,
  input wire rs485_rx,
  output wire rs485_tx,
  output wire rs485_tx_oe,
  output wire shared_pins_rs485,
  input wire [6:0] tx_char,
  input wire tx_char_valid,
  output wire tx_char_ready,
  output wire [6:0] rx_char,
  output wire rx_char_valid,
  output wire rx_parity_err,
  output wire line_done,
  output wire banner_req,
  input wire banner_done,
  output wire run_active,
  input wire run_start,
  input wire stop_cmd,
  input wire poll_open,
  input wire poll_close,
  input wire mode_wr,
  input wire [1:0] mode_wr_val,
  output wire store_wr,
  output wire [1:0] store_mode
);
  localparam [`RUP_CNT_W-1:0] BIT_CNT = BIT_CYCLES[`RUP_CNT_W-1:0] - 1'b1;
  localparam [`RUP_CNT_W-1:0] HALF_CNT = BIT_CYCLES[`RUP_CNT_W:1] - 1'b1;
  localparam [2:0] ST_BOOT = 3'h0;
  localparam [2:0] ST_BANNER = 3'h1;
  localparam [2:0] ST_CMD = 3'h2;
  localparam [2:0] ST_RUN = 3'h3;
  localparam [2:0] ST_POLL = 3'h4;

  function par_even;
    input [`RUP_DATA_BITS-1:0] d;
    begin
      par_even = ^d;
    end
  endfunction

  reg [2:0] st_q;
  reg [1:0] boot_cnt_q;
  reg route_q;
  reg link_en_q;
  reg [2:0] btn_s_q;
  reg [2:0] rx_s_q;
  reg btn_q;
  reg rx_lvl_q;
  reg store_wr_q;
  reg [1:0] store_mode_q;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    btn_s_q <= {btn_s_q[1:0], adjust_button};
    rx_s_q <= {rx_s_q[1:0], rs485_rx};
    if (rst) begin
      btn_q <= 1'b0;
      rx_lvl_q <= 1'b1;
    end else begin
      if (btn_s_q[1] == btn_s_q[2]) begin
        btn_q <= btn_s_q[2];
      end
      if (rx_s_q[1] == rx_s_q[2]) begin
        rx_lvl_q <= rx_s_q[2];
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  wire [6:0] fifo_data;
  wire fifo_valid;
  wire tx_take;
  reg tx_busy_q;
  reg [9:0] tx_sh_q;
  reg [`RUP_CNT_W-1:0] tx_cnt_q;
  reg [`RUP_BIT_IDX_W-1:0] tx_idx_q;
  // Poll mode holds the buffer so nothing leaves until addressed
  // silent until addressed
  wire tx_allowed = link_en_q && (st_q != ST_BOOT) && (st_q != ST_POLL);

  rup_fifo #(
    .WIDTH(`RUP_DATA_BITS),
    .DEPTH(`RUP_FIFO_DEPTH),
    .AW(`RUP_FIFO_AW)
  ) u_txq (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_data(tx_char),
    .in_valid(tx_char_valid),
    .in_ready(tx_char_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(tx_take)
  );

  assign tx_take = !tx_busy_q && tx_allowed;

  always @(posedge sys_clk) begin
    if (rst) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 10'h3ff;
      tx_cnt_q <= {`RUP_CNT_W{1'b0}};
      tx_idx_q <= {`RUP_BIT_IDX_W{1'b0}};
    end else if (!tx_busy_q) begin
      if (tx_take && fifo_valid) begin
        // 7 data, even parity, 1 stop
        tx_sh_q <= {1'b1, par_even(fifo_data), fifo_data, 1'b0};
        tx_busy_q <= 1'b1;
        tx_cnt_q <= BIT_CNT;
        tx_idx_q <= {`RUP_BIT_IDX_W{1'b0}};
      end
    end else if (tx_cnt_q != {`RUP_CNT_W{1'b0}}) begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end else if (tx_idx_q == `RUP_STOP_POS) begin
      tx_busy_q <= 1'b0;
    end else begin
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      tx_idx_q <= tx_idx_q + 1'b1;
      tx_cnt_q <= BIT_CNT;
    end
  end

  assign rs485_tx = tx_sh_q[0];
  assign rs485_tx_oe = tx_busy_q;

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  reg rx_busy_q;
  reg [`RUP_CNT_W-1:0] rx_cnt_q;
  reg [`RUP_BIT_IDX_W-1:0] rx_idx_q;
  reg [7:0] rx_sh_q;
  reg [6:0] rx_char_q;
  reg rx_valid_q;
  reg rx_perr_q;
  reg line_done_q;
  // Anything queued counts as an answer in progress
  // no reception while answering
  wire rx_blocked = tx_busy_q || fifo_valid || !link_en_q || (st_q == ST_BOOT) || (st_q == ST_BANNER);

  always @(posedge sys_clk) begin
    if (rst) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= {`RUP_CNT_W{1'b0}};
      rx_idx_q <= {`RUP_BIT_IDX_W{1'b0}};
      rx_sh_q <= 8'h00;
      rx_char_q <= 7'h00;
      rx_valid_q <= 1'b0;
      rx_perr_q <= 1'b0;
      line_done_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      line_done_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_lvl_q && !rx_blocked) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= HALF_CNT;
          rx_idx_q <= {`RUP_BIT_IDX_W{1'b0}};
        end
      end else if (rx_blocked) begin
        rx_busy_q <= 1'b0;
      end else if (rx_cnt_q != {`RUP_CNT_W{1'b0}}) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= BIT_CNT;
        rx_idx_q <= rx_idx_q + 1'b1;
        if (rx_idx_q == {`RUP_BIT_IDX_W{1'b0}}) begin
          // Glitch shorter than half a bit is not a start
          rx_busy_q <= !rx_lvl_q;
        end else if (rx_idx_q != `RUP_STOP_POS) begin
          rx_sh_q <= {rx_lvl_q, rx_sh_q[7:1]};
        end else begin
          rx_busy_q <= 1'b0;
          // Frames without a stop bit are dropped
          if (rx_lvl_q) begin
            rx_char_q <= rx_sh_q[6:0];
            rx_perr_q <= (par_even(rx_sh_q[6:0]) != rx_sh_q[7]);
            rx_valid_q <= 1'b1;
            line_done_q <= (rx_sh_q[6:0] == `RUP_CHAR_CR);
          end
        end
      end
    end
  end

  // received data never reaches the transmitter
  assign rx_char = rx_char_q;
  assign rx_char_valid = rx_valid_q;
  assign rx_parity_err = rx_perr_q;
  assign line_done = line_done_q;

  // ----------------------------------------
  // Start-up and mode control
  // ----------------------------------------
  wire esc_rx = rx_valid_q && (rx_char_q == `RUP_CHAR_ESC);

  always @(posedge sys_clk) begin
    if (rst) begin
      st_q <= ST_BOOT;
      boot_cnt_q <= 2'h0;
      route_q <= 1'b0;
      link_en_q <= 1'b0;
      store_wr_q <= 1'b0;
      store_mode_q <= `RUP_MODE_STOP;
    end else begin
      store_wr_q <= 1'b0;
      if (mode_wr) begin
        store_wr_q <= 1'b1;
        store_mode_q <= mode_wr_val;
      end
      case (st_q)
        ST_BOOT: begin
          boot_cnt_q <= boot_cnt_q + 1'b1;
          // Button chain shifts through reset, so it has settled here
          if (boot_cnt_q == `RUP_SYNC_SETTLE) begin
            route_q <= passive_variant && btn_q;
            link_en_q <= !passive_variant || btn_q;
            case (stored_mode)
              `RUP_MODE_RUN: st_q <= ST_RUN;
              `RUP_MODE_POLL: st_q <= ST_POLL;
              default: st_q <= ST_BANNER;
            endcase
          end
        end
        ST_BANNER: begin
          if (banner_done) begin
            st_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (run_start) begin
            st_q <= ST_RUN;
          end else if (poll_close && stored_mode == `RUP_MODE_POLL) begin
            st_q <= ST_POLL;
          end
        end
        ST_RUN: begin
          if (stop_cmd || esc_rx) begin
            st_q <= ST_CMD;
          end
        end
        ST_POLL: begin
          if (poll_open) begin
            st_q <= ST_CMD;
          end
        end
        default: st_q <= ST_BOOT;
      endcase
    end
  end

  assign shared_pins_rs485 = route_q;
  assign banner_req = (st_q == ST_BANNER);
  assign run_active = (st_q == ST_RUN);
  assign store_wr = store_wr_q;
  assign store_mode = store_mode_q;
endmodule

/* File: tb/rup_host_model.sv */
// Host on the two-wire bus: sends 7E1 characters and decodes device frames.
// Assumes the bench resolves the bus level; released bus idles high by bias.
`timescale 1ns/1ps
module rup_host_model #(
  parameter BIT = 16
) (
  input wire sys_clk,
  input wire bus,
  output logic host_line
);
  logic [7:0] sh;
  logic host_en = 1'b0;
  logic [6:0] rx_c;
  logic rx_p;
  int n_rx = 0;
  initial host_line = 1'b1;
  // ----------------------------------------
  // Sending
  // ----------------------------------------
  // never faster, 7E1
  task send(input logic [6:0] c, input logic p);
    logic [9:0] f;
    f = {1'b1, p, c, 1'b0};
    @(posedge sys_clk) #1;
    host_en = 1'b1;
    for (int i = 0; i < 10; i++) begin
      host_line = f[i];
      repeat (BIT) @(posedge sys_clk) #1;
    end
    host_en = 1'b0;
  endtask
  // ----------------------------------------
  // Receiving
  // ----------------------------------------
  // decode device frames
  always begin
    @(negedge bus);
    if (!host_en) begin
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge sys_clk);
        sh[i] = bus;
      end
      rx_c = sh[6:0];
      rx_p = sh[7];
      n_rx++;
    end
  end
endmodule

/* File: tb/rup_user_port_chk.sv */
// Checker for the user port: line framing, receive blocking, run control, store.
// Assumes the single port clock and synchronous active-high reset.
`timescale 1ns/1ps
`include "rup_consts.vh"
module rup_user_port_chk #(
  parameter BIT_CYCLES = 16
) (
  input wire sys_clk,
  input wire rst,
  input wire adjust_button,
  input wire passive_variant,
  input wire rs485_tx,
  input wire rs485_tx_oe,
  input wire shared_pins_rs485,
  input wire [6:0] rx_char,
  input wire rx_char_valid,
  input wire line_done,
  input wire run_active,
  input wire stop_cmd,
  input wire mode_wr,
  input wire [1:0] mode_wr_val,
  input wire store_wr,
  input wire [1:0] store_mode
);
  int oe_cnt = 0;
  // ----------------------------------------
  // Cycles of the current driven frame
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst || !rs485_tx_oe)
      oe_cnt <= 0;
    else
      oe_cnt <= oe_cnt + 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_idle_mark: assert property (!rs485_tx_oe |-> rs485_tx)
    else $error("line not idle high");
  a_start_low: assert property ($rose(rs485_tx_oe) |-> !rs485_tx)
    else $error("frame without start bit");
  a_frame_len: assert property ($fell(rs485_tx_oe) |-> oe_cnt == 10 * BIT_CYCLES)
    else $error("frame length wrong");
  a_stop_mark: assert property (rs485_tx_oe && oe_cnt >= 9 * BIT_CYCLES |-> rs485_tx)
    else $error("stop bit not high");
  a_rx_blocked: assert property (rs485_tx_oe |-> !rx_char_valid)
    else $error("char taken while sending");
  a_cr_line: assert property (line_done |-> rx_char_valid && rx_char == `RUP_CHAR_CR)
    else $error("line end without return");
  a_stop_run: assert property (run_active && stop_cmd |=> !run_active)
    else $error("stop did not end run");
  a_esc_run: assert property (run_active && rx_char_valid && rx_char == `RUP_CHAR_ESC |=> !run_active)
    else $error("escape did not end run");
  a_store_copy: assert property (mode_wr |=> store_wr && store_mode == $past(mode_wr_val))
    else $error("mode not stored");
  a_route_cause: assert property ($rose(shared_pins_rs485) |-> passive_variant && adjust_button)
    else $error("routing without button");
  a_route_hold: assert property (shared_pins_rs485 |=> shared_pins_rs485)
    else $error("routing lost in session");
  c_frame: cover property ($fell(rs485_tx_oe));
  c_line: cover property (line_done);
  c_run_end: cover property ($fell(run_active));
  c_store: cover property (store_wr);
endmodule
bind rup_user_port rup_user_port_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.sys_clk, .rst, .adjust_button,
  .passive_variant, .rs485_tx, .rs485_tx_oe, .shared_pins_rs485, .rx_char, .rx_char_valid, .line_done,
  .run_active, .stop_cmd, .mode_wr, .mode_wr_val, .store_wr, .store_mode);

/* File: tb/rup_user_port_tb.sv */
// Bench for the user port: start-up per stored mode, framing both ways, run control.
// Assumes the host model on the bus and a short bit time for speed.
`timescale 1ns/1ps
`include "rup_consts.vh"
module rup_user_port_tb;
  localparam int B = 16;
  typedef struct {logic [6:0] c; logic p; logic e;} rup_row_t;
  rup_row_t rows [5] = '{'{7'h41, 1'b0, 1'b0}, '{7'h55, 1'b0, 1'b0}, '{7'h7f, 1'b1, 1'b0},
    '{7'h2a, 1'b1, 1'b0}, '{7'h13, 1'b0, 1'b1}};
  logic sys_clk = 1'b0, rst = 1'b1, adjust_button = 1'b0, passive_variant = 1'b0, host_line;
  logic [1:0] stored_mode = 2'h0, mode_wr_val = 2'h0, store_mode;
  logic [6:0] tx_char = 7'h00, rx_char;
  logic tx_char_valid = 1'b0, banner_done = 1'b0, run_start = 1'b0, stop_cmd = 1'b0, poll_open = 1'b0;
  logic poll_close = 1'b0, mode_wr = 1'b0, rs485_rx, rs485_tx, rs485_tx_oe, shared_pins_rs485, tx_char_ready;
  logic rx_char_valid, rx_parity_err, line_done, banner_req, run_active, store_wr;
  int n_fail = 0, n_compared = 0, cyc = 0, n_rxv = 0, n_ld = 0, k, nh;
  always #5 sys_clk = ~sys_clk;
  assign rs485_rx = (rs485_tx_oe ? rs485_tx : 1'b1) & host_line;
  rup_user_port #(.BIT_CYCLES(B)) dut (.sys_clk, .rst, .adjust_button, .passive_variant, .stored_mode,
    .rs485_rx, .rs485_tx, .rs485_tx_oe, .shared_pins_rs485, .tx_char, .tx_char_valid, .tx_char_ready,
    .rx_char, .rx_char_valid, .rx_parity_err, .line_done, .banner_req, .banner_done, .run_active,
    .run_start, .stop_cmd, .poll_open, .poll_close, .mode_wr, .mode_wr_val, .store_wr, .store_mode);
  rup_host_model #(.BIT(B)) host (.sys_clk, .bus(rs485_rx), .host_line);
  // ----------------------------------------
  // Monitors and hang guard
  // ----------------------------------------
  always @(posedge sys_clk) begin
    n_rxv <= n_rxv + (rx_char_valid === 1'b1);
    n_ld <= n_ld + (line_done === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("[FAIL] timeout exp 0 got 1");
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Reset stands in for power-up
  task boot(input logic [1:0] m, input logic pv, input logic btn);
    rst = 1'b1;
    stored_mode = m;
    passive_variant = pv;
    adjust_button = btn;
    repeat (8) @(posedge sys_clk) #1;
    rst = 1'b0;
    repeat (8) @(posedge sys_clk) #1;
  endtask
  task push(input logic [6:0] c);
    tx_char = c;
    tx_char_valid = 1'b1;
    @(posedge sys_clk) #1;
    tx_char_valid = 1'b0;
  endtask
  // Bounded wait on device (dev=1) or host receive counts
  task wait_cnt(input bit dev, input int n);
    for (int j = 0; j < 4000 && (dev ? n_rxv : host.n_rx) < n; j++) @(posedge sys_clk);
    repeat (3 * B) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    boot(`RUP_MODE_STOP, 1'b0, 1'b0);
    chk("banner_req", 1, banner_req);
    chk("shared_off", 0, shared_pins_rs485);
    banner_done = 1'b1;
    @(posedge sys_clk) #1;
    banner_done = 1'b0;
    chk("banner_end", 0, banner_req);
    for (k = 0; k < 5; k++) begin
      push(rows[k].c);
      wait_cnt(0, k + 1);
      chk("tx_char", rows[k].c, host.rx_c);
      chk("tx_par", rows[k].p ^ rows[k].e, host.rx_p);
      host.send(rows[k].c, rows[k].p);
      wait_cnt(1, k + 1);
      chk("rx_char", rows[k].c, rx_char);
      chk("rx_err", rows[k].e, rx_parity_err);
    end
    host.send(`RUP_CHAR_CR, 1'b1);
    wait_cnt(1, 6);
    repeat (12 * B) @(posedge sys_clk) #1;
    chk("no_echo", 5, host.n_rx);
    chk("line_done", 1, n_ld);
    run_start = 1'b1;
    @(posedge sys_clk) #1;
    run_start = 1'b0;
    chk("run_on", 1, run_active);
    host.send(`RUP_CHAR_ESC, 1'b0);
    wait_cnt(1, 7);
    chk("esc_stop", 0, run_active);
    run_start = 1'b1;
    @(posedge sys_clk) #1;
    run_start = 1'b0;
    for (k = 0; k < 3 && run_active === 1'b1; k++) begin
      stop_cmd = 1'b1;
      @(posedge sys_clk) #1;
      stop_cmd = 1'b0;
      @(posedge sys_clk) #1;
    end
    chk("stop_run", 0, run_active);
    mode_wr_val = `RUP_MODE_POLL;
    mode_wr = 1'b1;
    @(posedge sys_clk) #1;
    mode_wr = 1'b0;
    chk("store_wr", 1, store_wr);
    chk("store_mode", `RUP_MODE_POLL, store_mode);
    push(7'h33);
    repeat (4) @(posedge sys_clk) #1;
    host.send(7'h41, 1'b0);
    repeat (12 * B) @(posedge sys_clk) #1;
    chk("rx_blocked", 7, n_rxv);
    // Answer starting mid-reception must drop the partial char
    fork
      host.send(7'h41, 1'b0);
      begin
        repeat (4 * B) @(posedge sys_clk) #1;
        push(7'h33);
      end
    join
    repeat (24 * B) @(posedge sys_clk) #1;
    chk("rx_abort", 7, n_rxv);
    boot(`RUP_MODE_RUN, 1'b0, 1'b0);
    chk("run_boot", 1, run_active);
    boot(`RUP_MODE_POLL, 1'b0, 1'b0);
    nh = host.n_rx;
    tx_char_valid = 1'b1;
    for (k = 0; k < 20 && tx_char_ready === 1'b1; k++) begin
      tx_char = k[6:0];
      @(posedge sys_clk) #1;
    end
    tx_char_valid = 1'b0;
    chk("fill", `RUP_FIFO_DEPTH + 1, k);
    repeat (12 * B) @(posedge sys_clk) #1;
    chk("poll_quiet", nh, host.n_rx);
    poll_open = 1'b1;
    @(posedge sys_clk) #1;
    poll_open = 1'b0;
    wait_cnt(0, nh + 17);
    chk("drain_last", 16, host.rx_c);
    boot(`RUP_MODE_STOP, 1'b1, 1'b1);
    chk("route_on", 1, shared_pins_rs485);
    boot(`RUP_MODE_STOP, 1'b1, 1'b0);
    chk("route_off", 0, shared_pins_rs485);
    report_and_stop();
  end
endmodule
